// [hdl/ckm_key_module.sv]
/*
  One key module: four-key selector, pin function outputs, a 16-bit sense
  cycle counter and the time slot counter.
  Assumes sense oscillator edges arrive as one-cycle pulses synchronous to clock.
*/
`timescale 1ns/100ps
module ckm_key_module (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // Controls
  input  wire ckm_pkg::ckm_ctrl_s ctrl,
  input  wire logic              ovf_clr,
  // Pads
  input  wire logic [3:0]        sense_pulse,
  output logic      [3:0]        touch_mode,
  // Status
  output ckm_pkg::ckm_stat_s     stat
);

  logic [15:0] count_reg;
  logic [12:0] slot_reg;
  logic [2:0]  pre_reg;
  logic        start_d_reg;
  logic        run_reg;
  logic        cov_reg;
  logic        done_reg;
  logic        sel_pulse;
  logic        ref_tick;
  logic [12:0] slot_len;

  // [R5] key routing
  // [R7] selector enable gate
  assign sel_pulse = sense_pulse[ctrl.key_sel] & ctrl.key_en[ctrl.key_sel]
                     & ctrl.key_fn[ctrl.key_sel];
  assign ref_tick  = (pre_reg == 3'(ckm_pkg::REF_DIV - 1));
  assign slot_len  = 13'(13'h1 << (ckm_pkg::SLOT_BASE_LOG2 + ctrl.slot_sel));

  // [R8] pin function
  always_ff @(posedge clock) begin
    if (rst) touch_mode <= 4'h0;
    else     touch_mode <= ctrl.key_fn;
  end

  // [R10] start edge
  always_ff @(posedge clock) begin
    if (rst) begin
      start_d_reg <= 1'b0;
      run_reg     <= 1'b0;
      pre_reg     <= 3'h0;
      slot_reg    <= ckm_pkg::SLOT_CNT_RST;
      done_reg    <= 1'b0;
    end else begin
      start_d_reg <= ctrl.start;
      done_reg    <= 1'b0;
      pre_reg     <= (ref_tick || !run_reg) ? 3'h0 : pre_reg + 3'h1;
      if (ctrl.slot_clr) begin
        slot_reg <= ckm_pkg::SLOT_CNT_RST;
        run_reg  <= 1'b0;
      end else if (ctrl.start && !start_d_reg && ctrl.ref_on) begin
        slot_reg <= ckm_pkg::SLOT_CNT_RST;
        run_reg  <= 1'b1;
      end else if (run_reg && ref_tick) begin
        // [R11] interval end
        if (slot_reg == slot_len - 13'h1) begin
          run_reg  <= 1'b0;
          done_reg <= 1'b1;
        end
        slot_reg <= slot_reg + 13'h1;
      end
    end
  end

  // [R12] clear control
  // [R14] count only
  always_ff @(posedge clock) begin
    if (rst) begin
      count_reg <= 16'h0000;
      cov_reg   <= 1'b0;
    end else begin
      cov_reg <= 1'b0;
      if (ctrl.count_clr) count_reg <= 16'h0000;
      else if (run_reg && ctrl.count_on) begin
        if (ctrl.src_sense ? sel_pulse : ref_tick) begin
          count_reg <= count_reg + 16'h1;
          // [R13] counter overflow
          cov_reg   <= (count_reg == 16'hffff);
        end
      end
    end
  end

  always_comb begin
    stat.count     = count_reg;
    stat.running   = run_reg;
    stat.count_ovf = cov_reg;
    stat.slot_ovf  = done_reg;
    stat.slot_done = done_reg;
  end

endmodule : ckm_key_module

// [hdl/ckm_pkg.sv]
/*
  Package for the capacitive key scan block: register indices, field
  positions, reset values, measurement timing and the carrier structs.
  Assumes a single 125 MHz clock and an APB register bus with 32-bit data.
*/
package ckm_pkg;

  localparam int unsigned N_MODULES      = 6;
  localparam int unsigned KEYS_PER_MOD   = 4;
  localparam int unsigned REGS_PER_MOD   = 6;

  // Register index within a module; byte address = 4 * (module * 8 + index).
  localparam logic [2:0] IDX_COUNT_HIGH  = 3'h0;
  localparam logic [2:0] IDX_COUNT_LOW   = 3'h1;
  localparam logic [2:0] IDX_KEY_SELECT  = 3'h2;
  localparam logic [2:0] IDX_PIN_FUNC    = 3'h3;
  localparam logic [2:0] IDX_START_CTRL  = 3'h4;
  localparam logic [2:0] IDX_OVF_SETUP   = 3'h5;
  localparam logic [2:0] IDX_IRQ_MASK    = 3'h6;

  // Global registers placed above the module banks.
  localparam logic [5:0] IDX_IRQ_STATUS  = 6'h30;
  localparam logic [5:0] IDX_IRQ_ENABLE  = 6'h31;

  // Field positions.
  localparam int unsigned KSEL_LSB       = 6;
  localparam int unsigned KEN_LSB        = 4;
  localparam int unsigned KFN_LSB        = 0;
  localparam int unsigned ST_COUNT_ON    = 7;
  localparam int unsigned ST_START       = 5;
  localparam int unsigned ST_REF_ON      = 4;
  localparam int unsigned ST_SLOT_CLR    = 3;
  localparam int unsigned ST_COUNT_CLR   = 2;
  localparam int unsigned ST_SRC_SENSE   = 0;
  localparam int unsigned OV_SLOT        = 5;
  localparam int unsigned OV_COUNT       = 4;

  // Reset values and writable masks.
  localparam logic [7:0] RST_REG8        = 8'h00;
  localparam logic [7:0] START_WMASK     = 8'hbd;
  localparam logic [7:0] OVSET_WMASK     = 8'h17;
  localparam logic [5:0] KSEL_FILL       = 6'h18;

  // Time slot length is 64 << sel reference cycles; reference clock is the
  // system clock divided down by a fixed prescaler.
  localparam int unsigned SLOT_BASE_LOG2 = 6;
  localparam int unsigned REF_DIV        = 4;
  localparam logic [12:0] SLOT_CNT_RST   = 13'h0000;

  typedef struct packed {
    logic [1:0] key_sel;
    logic [3:0] key_en;
    logic [3:0] key_fn;
    logic       count_on;
    logic       ref_on;
    logic       src_sense;
    logic       start;
    logic       count_clr;
    logic       slot_clr;
    logic [2:0] slot_sel;
  } ckm_ctrl_s;

  typedef struct packed {
    logic [15:0] count;
    logic        running;
    logic        count_ovf;
    logic        slot_ovf;
    logic        slot_done;
  } ckm_stat_s;

endpackage : ckm_pkg

// [hdl/ckm_top.sv]
/*
  Capacitive key scan block: six key modules behind an APB slave, with
  sticky interrupt status, an enable mask and one level interrupt.
  Assumes APB signals synchronous to clock and synchronous active-high reset.
*/
// The APB slave port and the register offsets were chosen for this implementation.
// Behaviour
// [R1] Six modules M0..M5 of four keys, each with own control logic.
// [R2] Each module has six registers: two count bytes, four controls.
// [R3] Counter high byte readable, read-only, zero after reset.
// [R4] Counter low byte readable, read-only, zero after reset.
// [R5] Selector bits 7:6 of control zero route one of four keys.
// [R6] Software writes 011000 into low six bits of control zero.
// [R7] Control one bits 7:4 enable each key selector path.
// [R8] Control one bits 3:0 give each pin to I/O or touch.
// [R9] Pins map in module order, port B low through port D high.
// [R10] Start bit rising edge starts oscillators and time slot counter; here the slot counter also needs ref_on, pads run in touch mode.
// [R11] Count sense cycles over fixed interval, interrupt at its end.
// [R12] Clearing the counter needs its clear bit set then cleared.
// [R13] Each module flags counter overflow and time slot overflow.
// [R14] Count byte writes ignored; only counting or clear change them.
`timescale 1ns/100ps
module ckm_top (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Touch pads: port B 0..7, C 0..7, D 0..7
  input  wire logic [23:0] sense_pulse,
  output logic      [23:0] touch_mode,
  // Interrupt
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////////////
  localparam int unsigned NM = ckm_pkg::N_MODULES;

  logic [7:0]  key_select_control_reg   [NM];
  logic [7:0]  pin_function_control_reg [NM];
  logic [7:0]  counter_start_control_reg[NM];
  logic [7:0]  overflow_status_setup_reg[NM];
  logic [11:0] irq_status_reg;
  logic [11:0] irq_enable_reg;
  logic [11:0] irq_event;
  logic [11:0] irq_clear;
  logic [3:0]  mod_touch [NM];
  ckm_pkg::ckm_ctrl_s ctrl [NM];
  ckm_pkg::ckm_stat_s stat [NM];

  logic        acc;
  logic        wr;
  logic [5:0]  word;
  logic [2:0]  sub;
  logic [2:0]  mod;
  logic        mod_hit;

  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign word    = paddr[7:2];
  assign sub     = word[2:0];
  assign mod     = word[5:3];
  assign mod_hit = (mod < 3'(NM)) && (sub <= ckm_pkg::IDX_OVF_SETUP);

  function automatic logic [7:0] wmask(input logic [7:0] old, input logic [7:0] nw,
                                       input logic [7:0] m);
    wmask = (old & ~m) | (nw & m);
  endfunction : wmask

  //////////////////////////////////////////////////////////////////////////////
  // [R1] module replication
  // [R9] pin ordering
  for (genvar g = 0; g < NM; g++) begin : g_mod
    always_comb begin
      ctrl[g].key_sel   = key_select_control_reg[g][ckm_pkg::KSEL_LSB +: 2];
      ctrl[g].key_en    = pin_function_control_reg[g][ckm_pkg::KEN_LSB +: 4];
      ctrl[g].key_fn    = pin_function_control_reg[g][ckm_pkg::KFN_LSB +: 4];
      ctrl[g].count_on  = counter_start_control_reg[g][ckm_pkg::ST_COUNT_ON];
      ctrl[g].ref_on    = counter_start_control_reg[g][ckm_pkg::ST_REF_ON];
      ctrl[g].src_sense = counter_start_control_reg[g][ckm_pkg::ST_SRC_SENSE];
      ctrl[g].start     = counter_start_control_reg[g][ckm_pkg::ST_START];
      ctrl[g].count_clr = counter_start_control_reg[g][ckm_pkg::ST_COUNT_CLR];
      ctrl[g].slot_clr  = counter_start_control_reg[g][ckm_pkg::ST_SLOT_CLR];
      ctrl[g].slot_sel  = overflow_status_setup_reg[g][2:0];
    end

    ckm_key_module u_mod (
      .clock       (clock),
      .rst         (rst),
      .ctrl        (ctrl[g]),
      .ovf_clr     (1'b0),
      .sense_pulse (sense_pulse[4*g +: 4]),
      .touch_mode  (mod_touch[g]),
      .stat        (stat[g])
    );

    assign touch_mode[4*g +: 4] = mod_touch[g];
    // [R13] two events each
    // [R11] slot end event
    assign irq_event[2*g]   = stat[g].slot_ovf;
    assign irq_event[2*g+1] = stat[g].count_ovf;
  end

  //////////////////////////////////////////////////////////////////////////////
  // [R2] per-module registers
  // [R6] low bits kept as written
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < NM; i++) begin
        key_select_control_reg[i]    <= ckm_pkg::RST_REG8;
        pin_function_control_reg[i]  <= ckm_pkg::RST_REG8;
        counter_start_control_reg[i] <= ckm_pkg::RST_REG8;
      end
    end else if (wr && mod_hit) begin
      case (sub)
        ckm_pkg::IDX_KEY_SELECT: key_select_control_reg[mod]   <= pwdata[7:0];
        ckm_pkg::IDX_PIN_FUNC:   pin_function_control_reg[mod] <= pwdata[7:0];
        ckm_pkg::IDX_START_CTRL: counter_start_control_reg[mod] <=
          wmask(counter_start_control_reg[mod], pwdata[7:0], ckm_pkg::START_WMASK);
        // [R14] count bytes read-only
        default: ;
      endcase
    end
  end

  // The count overflow flag in the setup register is set by hardware, the set wins; the slot bit tracks the running slot.
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < NM; i++) overflow_status_setup_reg[i] <= ckm_pkg::RST_REG8;
    end else begin
      for (int i = 0; i < NM; i++) begin
        logic [7:0] v;
        v = overflow_status_setup_reg[i];
        if (wr && mod_hit && sub == ckm_pkg::IDX_OVF_SETUP && mod == 3'(i))
          v = wmask(v, pwdata[7:0], ckm_pkg::OVSET_WMASK);
        if (ctrl[i].start && !stat[i].running) v[ckm_pkg::OV_SLOT] = 1'b0;
        if (stat[i].running) v[ckm_pkg::OV_SLOT] = 1'b1;
        if (stat[i].slot_ovf) v[ckm_pkg::OV_SLOT] = 1'b0;
        if (stat[i].count_ovf) v[ckm_pkg::OV_COUNT] = 1'b1;
        overflow_status_setup_reg[i] <= v;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status: write one to clear, event wins over clear.
  assign irq_clear = (wr && word == ckm_pkg::IDX_IRQ_STATUS) ? pwdata[11:0] : 12'h000;

  always_ff @(posedge clock) begin
    if (rst) irq_status_reg <= 12'h000;
    else     irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
  end

  always_ff @(posedge clock) begin
    if (rst) irq_enable_reg <= 12'h000;
    else if (wr && word == ckm_pkg::IDX_IRQ_ENABLE) irq_enable_reg <= pwdata[11:0];
  end

  always_ff @(posedge clock) begin
    if (rst) irq <= 1'b0;
    else     irq <= |(((irq_status_reg & ~irq_clear) | irq_event) & irq_enable_reg);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Count bytes are read live, so software should read them once the slot has ended.
  // APB answers in the access phase's first cycle: ready registered from setup.
  always_ff @(posedge clock) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mod_hit & (word != ckm_pkg::IDX_IRQ_STATUS)
                 & (word != ckm_pkg::IDX_IRQ_ENABLE);
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (word == ckm_pkg::IDX_IRQ_STATUS)      prdata <= {20'h00000, irq_status_reg};
        else if (word == ckm_pkg::IDX_IRQ_ENABLE) prdata <= {20'h00000, irq_enable_reg};
        else if (mod_hit) begin
          case (sub)
            // [R3] high byte
            ckm_pkg::IDX_COUNT_HIGH: prdata <= {24'h000000, stat[mod].count[15:8]};
            // [R4] low byte
            ckm_pkg::IDX_COUNT_LOW:  prdata <= {24'h000000, stat[mod].count[7:0]};
            ckm_pkg::IDX_KEY_SELECT: prdata <= {24'h000000, key_select_control_reg[mod]};
            ckm_pkg::IDX_PIN_FUNC:   prdata <= {24'h000000, pin_function_control_reg[mod]};
            ckm_pkg::IDX_START_CTRL: prdata <= {24'h000000, counter_start_control_reg[mod]};
            ckm_pkg::IDX_OVF_SETUP:  prdata <= {24'h000000, overflow_status_setup_reg[mod]};
            default:                 prdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

endmodule : ckm_top

// [tb/ckm_pads.sv]
/*
  Touch pad model: every pad in touch mode runs a sense oscillator.
  Assumes one-cycle pulses synchronous to clock, as the block expects.
*/
`timescale 1ns/100ps
module ckm_pads #(
  parameter int unsigned PERIOD = 4
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Pads
  input  wire logic [23:0] touch_mode,
  output logic      [23:0] sense_pulse
);
  int unsigned ph_reg;
  always_ff @(posedge clock) begin
    if (rst) begin
      ph_reg <= 0;
      sense_pulse <= 24'h0;
    end else begin
      ph_reg <= (ph_reg == PERIOD - 1) ? 0 : ph_reg + 1;
      // pad 4m+k is key k of module m
      // a pad left as plain I/O has no oscillator
      sense_pulse <= (ph_reg == 0) ? touch_mode : 24'h0;
    end
  end
endmodule : ckm_pads

// [tb/ckm_top_properties.sv]
/*
  Checker for the key scan top: bus timing, read-back shape, pad mode copy.
  Assumes it is bound to ckm_top and sees only its ports.
*/
`timescale 1ns/100ps
module ckm_top_properties (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Pads and interrupt
  input wire logic [23:0] sense_pulse,
  input wire logic [23:0] touch_mode,
  input wire logic        irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic       acc;
  logic [3:0] fn_reg;
  assign acc = psel && penable && pready;
  always_ff @(posedge clock) begin
    if (acc && pwrite && paddr == 8'h0c) begin
      fn_reg <= pwdata[3:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_ready_first: assert property (psel && !penable |=> pready)
    else $error("no answer in first access cycle");
  a_ready_only: assert property (pready |-> psel && penable)
    else $error("answer outside an access");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside an answer");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without answer");
  a_err_hole: assert property (acc && paddr < 8'hc0 && paddr[4:2] > 3'h5 |-> pslverr)
    else $error("hole in a module bank accepted");
  a_count_byte: assert property (acc && !pwrite && paddr < 8'hc0 && paddr[4:3] == 2'h0
    |-> prdata[31:8] == 24'h0)
    else $error("count byte wider than eight bits");
  a_touch_copy: assert property (acc && pwrite && paddr == 8'h0c
    |-> ##[1:2] touch_mode[3:0] == fn_reg)
    else $error("pad mode does not follow its register");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !pready && !irq && touch_mode == 24'h0)
    else $error("outputs active through reset");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_touch: cover property (acc && pwrite && paddr == 8'h0c);
endmodule : ckm_top_properties

bind ckm_top ckm_top_properties chk (.clock(clock), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .sense_pulse(sense_pulse),
  .touch_mode(touch_mode), .irq(irq));

// [tb/tb_capacitive_key_scan_module.sv]
/*
  Testbench for the key scan top: register table, reset, a measurement and
  its interrupt. Assumes the pad model beside it and APB answers as noted.
*/
`timescale 1ns/100ps
module tb_capacitive_key_scan_module;
  typedef struct packed {
    logic        w;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] r;
    logic        e;
  } ckm_row_s;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, lo;
  logic [23:0] sense_pulse, touch_mode;
  int          n_mismatch, total_checks, i;
  ckm_row_s    rows [12] = '{
    '{1'b1, 8'h08, 32'hd8, 32'h0, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'hd8, 1'b0},
    '{1'b1, 8'h0c, 32'h5a, 32'h0, 1'b0},
    '{1'b0, 8'h0c, 32'h0, 32'h5a, 1'b0},
    '{1'b1, 8'h00, 32'hff, 32'h0, 1'b0},
    '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0},
    '{1'b1, 8'h04, 32'hff, 32'h0, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h18, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'hac, 32'ha5, 32'h0, 1'b0},
    '{1'b0, 8'hac, 32'h0, 32'ha5, 1'b0},
    '{1'b1, 8'h28, 32'h18, 32'h0, 1'b0}};
  ckm_top uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .sense_pulse(sense_pulse), .touch_mode(touch_mode), .irq(irq));
  ckm_pads #(.PERIOD(4)) pads (.clock(clock), .rst(rst), .touch_mode(touch_mode),
    .sense_pulse(sense_pulse));
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk_val
  task automatic chk_bit(input logic got, input logic exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %b", $time, m, got);
    end
  endtask : chk_bit
  // Holds the request until pready is seen, then idles one cycle.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("[FAIL] %0t bus hang", $time);
      close_out();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    n_mismatch = 0;
    total_checks = 0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int k = 0; k < 12; k++) begin
      apb(rows[k].w, rows[k].a, rows[k].d, rd, er);
      if (!rows[k].w) chk_val(rd, rows[k].r, "read back");
      chk_bit(er, rows[k].e, "bus error");
    end
    chk_val({8'h0, touch_mode}, 32'h0050000a, "pad mode");
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int m = 0; m < 6; m++) begin
      for (int x = 0; x < 6; x++) begin
        apb(1'b0, 8'(4 * (m * 8 + x)), 32'h0, rd, er);
        chk_val(rd, 32'h0, "reset value");
      end
    end
    // Module 1 measures its second key for a 256-cycle slot.
    apb(1'b1, 8'h2c, 32'hff, rd, er);
    apb(1'b1, 8'h28, 32'h58, rd, er);
    apb(1'b1, 8'hc4, 32'h04, rd, er);
    apb(1'b1, 8'h30, 32'h91, rd, er);
    apb(1'b1, 8'h30, 32'hb1, rd, er);
    // The running flag reaches the setup register two edges after the start write.
    @(posedge clock);
    apb(1'b0, 8'h34, 32'h0, rd, er);
    chk_bit(rd[5], 1'b1, "slot running");
    for (i = 0; i < 2000 && irq !== 1'b1; i++) @(posedge clock);
    chk_bit(irq, 1'b1, "slot end irq");
    if (irq !== 1'b1) close_out();
    apb(1'b0, 8'h24, 32'h0, lo, er);
    apb(1'b0, 8'h20, 32'h0, rd, er);
    chk_bit({rd[7:0], lo[7:0]} >= 16'd62 && {rd[7:0], lo[7:0]} <= 16'd66, 1'b1, "count");
    apb(1'b1, 8'hc4, 32'h0, rd, er);
    // The interrupt output is registered one edge behind its mask.
    @(posedge clock);
    chk_bit(irq, 1'b0, "masked irq");
    apb(1'b0, 8'hc0, 32'h0, rd, er);
    chk_val(rd & 32'h4, 32'h4, "sticky status");
    apb(1'b1, 8'hc0, 32'h4, rd, er);
    apb(1'b1, 8'hc4, 32'h4, rd, er);
    @(posedge clock);
    chk_bit(irq, 1'b0, "cleared irq");
    apb(1'b1, 8'h30, 32'h04, rd, er);
    apb(1'b1, 8'h30, 32'h00, rd, er);
    apb(1'b0, 8'h24, 32'h0, rd, er);
    chk_val(rd, 32'h0, "count cleared");
    close_out();
  end
endmodule : tb_capacitive_key_scan_module
